// File: ccdf_map.vh
`ifndef CCDF_MAP_VH
`define CCDF_MAP_VH
`define CCDF_ADDR_CTRL1     4'h0
`define CCDF_ADDR_PGA       4'h1
`define CCDF_ADDR_DAC1      4'h2
`define CCDF_ADDR_DAC2      4'h3
`define CCDF_ADDR_SDELAY    4'h4
`define CCDF_ADDR_BLACK     4'h5
`define CCDF_ADDR_CFG2      4'h6
`define CCDF_REG_RESET      10'h000
`define CCDF_C1_GLOBAL_STANDBY_BIT    9
`define CCDF_C1_AUX_DAC2_POWERDOWN_BIT    8
`define CCDF_C1_AUX_DAC1_POWERDOWN_BIT    7
`define CCDF_C1_SUST_BIT    6
`define CCDF_C1_SWRST_BIT   0
`define CCDF_C2_DLY_HI      9
`define CCDF_C2_DLY_LO      6
`define CCDF_C2_GND_BIT     2
`define CCDF_C2_MODE_BIT    1
`define CCDF_BK_EN_BIT      4
`define CCDF_FRAME_BITS     5'h10
`define CCDF_PIPE_DEPTH     5
`define CCDF_GAIN_CCD_MAX   10'h2FF
`define CCDF_GAIN_VID_BASE  10'h100
`define CCDF_VIDEO_OFFSET   10'h03C
`define CCDF_BLACK_BASE     10'h014
`define CCDF_DELAY_STEP_PS  500
`define CCDF_SETTLE_PIX     1000
`endif

// File: ccdf_skid.v
`timescale 1ns/100ps
// Two-entry buffer, full throughput, registered data
module ccdf_skid (
  clk,
  rst,
  ce,
  in_data,
  in_valid,
  in_ready,
  out_data,
  out_valid,
  out_ready
);
  input  wire       clk;
  input  wire       rst;
  input  wire       ce;
  input  wire [9:0] in_data;
  input  wire       in_valid;
  output wire       in_ready;
  output wire [9:0] out_data;
  output wire       out_valid;
  input  wire       out_ready;

  reg [9:0] mem_q [0:1];
  reg       wp_q;
  reg       rp_q;
  reg [1:0] cnt_q;
  wire      push;
  wire      pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (rst) begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= 10'h000;
      mem_q[1] <= 10'h000;
    end else if (ce) begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // ccdf_skid

// File: ccdf_frontend.v
`timescale 1ns/100ps
`include "ccdf_map.vh"
module ccdf_frontend (
  clk,
  rst,
  ce,
  serial_clk,
  serial_config_data,
  serial_sel_n,
  hw_standby_n,
  black_cal_window_n,
  blanking_pulse,
  conv_data,
  conv_valid,
  conv_ready,
  out_enable_n,
  out_ready,
  out_data,
  out_data_oe,
  out_valid,
  conv_clock_delay_sel,
  video_input_ground_short,
  input_channel_select,
  pga_gain_code,
  pga_gain_step,
  sample_delay_code,
  black_target_enable,
  black_target_level,
  black_target_code,
  black_cal_active,
  black_settled,
  aux_dac1_code,
  aux_dac2_code,
  aux_dac1_active,
  aux_dac2_active,
  global_standby
);
  input  wire       clk;
  input  wire       rst;
  input  wire       ce;
  input  wire       serial_clk;
  input  wire       serial_config_data;
  input  wire       serial_sel_n;
  input  wire       hw_standby_n;
  input  wire       black_cal_window_n;
  input  wire       blanking_pulse;
  input  wire [9:0] conv_data;
  input  wire       conv_valid;
  output wire       conv_ready;
  input  wire       out_enable_n;
  input  wire       out_ready;
  output wire [9:0] out_data;
  output wire       out_data_oe;
  output wire       out_valid;
  output wire [3:0] conv_clock_delay_sel;
  output wire       video_input_ground_short;
  output wire       input_channel_select;
  output reg  [9:0] pga_gain_code;
  output reg  [9:0] pga_gain_step;
  output wire [7:0] sample_delay_code;
  output wire       black_target_enable;
  output wire [3:0] black_target_level;
  output reg  [9:0] black_target_code;
  output wire       black_cal_active;
  output wire       black_settled;
  output wire [7:0] aux_dac1_code;
  output wire [7:0] aux_dac2_code;
  output wire       aux_dac1_active;
  output wire       aux_dac2_active;
  output wire       global_standby;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  wire      s_sck;
  wire      s_sdi;
  wire      s_sel_n;
  wire      s_global_standby_n;
  wire      s_win_n;
  wire      s_blank;

  always @(posedge clk) begin
    if (rst) begin
      // Idle levels: no false clock edge, window and standby off
      sync1_q <= 6'h0E;
      sync2_q <= 6'h0E;
    end else if (ce) begin
      sync1_q <= {serial_clk, serial_config_data, serial_sel_n, hw_standby_n,
                  black_cal_window_n, blanking_pulse};
      sync2_q <= sync1_q;
    end
  end
  assign s_sck    = sync2_q[5];
  assign s_sdi    = sync2_q[4];
  assign s_sel_n  = sync2_q[3];
  assign s_global_standby_n = sync2_q[2];
  assign s_win_n  = sync2_q[1];
  assign s_blank  = sync2_q[0];

  ////////////////////////////////////////////////////////////////////
  // Serial write shifter
  reg        sck_d1_q;
  reg [15:0] shift_q;
  reg [4:0]  bits_q;
  wire       sck_rise;
  wire       frame_done;

  assign sck_rise   = s_sck & ~sck_d1_q;
  assign frame_done = ~s_sel_n & sck_rise & (bits_q == `CCDF_FRAME_BITS - 5'h01);

  always @(posedge clk) begin
    if (rst) begin
      sck_d1_q <= 1'b0;
      shift_q  <= 16'h0000;
      bits_q   <= 5'h00;
    end else if (ce) begin
      sck_d1_q <= s_sck;
      if (s_sel_n) begin
        bits_q <= 5'h00;
      end else if (sck_rise && bits_q != `CCDF_FRAME_BITS) begin
        shift_q <= {shift_q[14:0], s_sdi};
        bits_q  <= bits_q + 5'h01;
      end
    end
  end

  wire [15:0] frame_word;
  wire [3:0]  wr_addr;
  wire [9:0]  wr_data;
  wire        wr_ok;
  assign frame_word = {shift_q[14:0], s_sdi};
  assign wr_addr    = frame_word[13:10];
  assign wr_data    = frame_word[9:0];
  assign wr_ok      = frame_done & (frame_word[15:14] == 2'b00);

  ////////////////////////////////////////////////////////////////////
  // Register file
  reg [9:0] ctrl1_q;
  reg [9:0] pga_q;
  reg [9:0] dac1_q;
  reg [9:0] dac2_q;
  reg [9:0] sdelay_q;
  reg [9:0] black_q;
  reg [9:0] cfg2_q;
  wire      sw_reset;

  assign sw_reset = wr_ok & (wr_addr == `CCDF_ADDR_CTRL1) & wr_data[`CCDF_C1_SWRST_BIT];

  always @(posedge clk) begin
    if (rst || (ce && sw_reset)) begin
      ctrl1_q  <= `CCDF_REG_RESET;
      pga_q    <= `CCDF_REG_RESET;
      dac1_q   <= `CCDF_REG_RESET;
      dac2_q   <= `CCDF_REG_RESET;
      sdelay_q <= `CCDF_REG_RESET;
      black_q  <= `CCDF_REG_RESET;
      cfg2_q   <= `CCDF_REG_RESET;
    end else if (ce && wr_ok) begin
      case (wr_addr)
        `CCDF_ADDR_CTRL1:  ctrl1_q  <= wr_data;
        `CCDF_ADDR_PGA:    pga_q    <= wr_data;
        `CCDF_ADDR_DAC1:   dac1_q   <= wr_data;
        `CCDF_ADDR_DAC2:   dac2_q   <= wr_data;
        `CCDF_ADDR_SDELAY: sdelay_q <= wr_data;
        `CCDF_ADDR_BLACK:  black_q  <= wr_data;
        `CCDF_ADDR_CFG2:   cfg2_q   <= wr_data;
        default: ;
      endcase
    end
  end

  assign conv_clock_delay_sel     = cfg2_q[`CCDF_C2_DLY_HI:`CCDF_C2_DLY_LO];
  assign video_input_ground_short = cfg2_q[`CCDF_C2_GND_BIT];
  assign input_channel_select     = cfg2_q[`CCDF_C2_MODE_BIT];
  assign sample_delay_code        = sdelay_q[7:0];
  assign black_target_enable      = black_q[`CCDF_BK_EN_BIT];
  assign black_target_level       = black_q[3:0];
  assign aux_dac1_code            = dac1_q[7:0];
  assign aux_dac2_code            = dac2_q[7:0];

  ////////////////////////////////////////////////////////////////////
  // Power state
  assign global_standby  = ~s_global_standby_n | ctrl1_q[`CCDF_C1_GLOBAL_STANDBY_BIT];
  assign aux_dac1_active = ~ctrl1_q[`CCDF_C1_AUX_DAC1_POWERDOWN_BIT] &
                           (~global_standby | ctrl1_q[`CCDF_C1_SUST_BIT]);
  assign aux_dac2_active = ~ctrl1_q[`CCDF_C1_AUX_DAC2_POWERDOWN_BIT] &
                           (~global_standby | ctrl1_q[`CCDF_C1_SUST_BIT]);

  ////////////////////////////////////////////////////////////////////
  // Gain step mapping and black target
  always @(posedge clk) begin
    if (rst) begin
      pga_gain_code     <= 10'h000;
      pga_gain_step     <= 10'h000;
      black_target_code <= 10'h000;
    end else if (ce) begin
      pga_gain_code <= pga_q;
      if (!input_channel_select)
        pga_gain_step <= (pga_q > `CCDF_GAIN_CCD_MAX) ? `CCDF_GAIN_CCD_MAX : pga_q;
      else if (pga_q < `CCDF_GAIN_VID_BASE)
        pga_gain_step <= 10'h000;
      else
        pga_gain_step <= pga_q - `CCDF_GAIN_VID_BASE;
      black_target_code <= black_target_enable ?
                           (`CCDF_BLACK_BASE + {6'h00, black_target_level}) : 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Black calibration window and settle count
  reg [9:0] settle_q;
  assign black_cal_active = ~s_win_n & ~global_standby;
  assign black_settled    = (settle_q == `CCDF_SETTLE_PIX - 1);

  always @(posedge clk) begin
    if (rst || (ce && sw_reset)) begin
      settle_q <= 10'h000;
    end else if (ce && black_cal_active && conv_valid && !black_settled) begin
      settle_q <= settle_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Five-stage output pipeline
  wire [9:0]                  pipe_w [0:`CCDF_PIPE_DEPTH-1];
  wire [`CCDF_PIPE_DEPTH-1:0] pv_w;
  wire      adv;
  wire      sk_in_ready;
  reg [9:0] stage0;
  reg [10:0] sum;

  assign adv        = ~pv_w[`CCDF_PIPE_DEPTH-1] | sk_in_ready;
  assign conv_ready = adv;

  always @* begin
    sum = {1'b0, conv_data};
    if (input_channel_select)
      sum = {1'b0, conv_data} + {1'b0, `CCDF_VIDEO_OFFSET};
    stage0 = sum[10] ? 10'h3FF : sum[9:0];
    if (s_blank)
      stage0 = 10'h000;
  end

  // Whole pipe stalls together, so no stage overwrites a held word
  genvar g;
  generate
    for (g = 0; g < `CCDF_PIPE_DEPTH; g = g + 1) begin : g_pipe
      reg  [9:0] data_q;
      reg        vld_q;
      wire [9:0] src_data;
      wire       src_vld;
      // Head takes the new sample, the rest the stage before
      if (g == 0) begin : g_head
        assign src_data = stage0;
        assign src_vld  = conv_valid;
      end else begin : g_tail
        assign src_data = pipe_w[g-1];
        assign src_vld  = pv_w[g-1];
      end
      always @(posedge clk) begin
        if (rst) begin
          data_q <= 10'h000;
          vld_q  <= 1'b0;
        end else if (ce && adv) begin
          data_q <= src_data;
          vld_q  <= src_vld;
        end
      end
      assign pipe_w[g] = data_q;
      assign pv_w[g]   = vld_q;
    end
  endgenerate

  wire [9:0] sk_data;
  ccdf_skid u_skid (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (pipe_w[`CCDF_PIPE_DEPTH-1]),
    .in_valid  (pv_w[`CCDF_PIPE_DEPTH-1]),
    .in_ready  (sk_in_ready),
    .out_data  (sk_data),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );

  ////////////////////////////////////////////////////////////////////
  // Output tri-state control, sampled pin
  reg oe_n_s1_q;
  reg oe_n_s2_q;
  always @(posedge clk) begin
    if (rst) begin
      oe_n_s1_q <= 1'b1;
      oe_n_s2_q <= 1'b1;
    end else if (ce) begin
      oe_n_s1_q <= out_enable_n;
      oe_n_s2_q <= oe_n_s1_q;
    end
  end
  assign out_data    = sk_data;
  assign out_data_oe = ~oe_n_s2_q;
endmodule // ccdf_frontend

// File: ccdf_frontend_asserts.sv
`timescale 1ns/100ps
module ccdf_frontend_asserts (
  input logic       clk,
  input logic       rst,
  input logic       out_enable_n,
  input logic       out_data_oe,
  input logic       hw_standby_n,
  input logic       global_standby,
  input logic       black_cal_window_n,
  input logic       black_cal_active,
  input logic       input_channel_select,
  input logic [9:0] pga_gain_code,
  input logic [9:0] pga_gain_step,
  input logic       black_target_enable,
  input logic [3:0] black_target_level,
  input logic [9:0] black_target_code,
  input logic [3:0] conv_clock_delay_sel,
  input logic       video_input_ground_short,
  input logic       out_valid,
  input logic       out_ready,
  input logic [9:0] out_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  a_oe_float: assert property (out_enable_n [*3] |-> !out_data_oe)
    else $error("output bus driven while disabled");
  a_pin_standby: assert property (!hw_standby_n [*3] |-> global_standby)
    else $error("standby pin ignored");
  a_cal_window: assert property (black_cal_window_n [*3] |-> !black_cal_active)
    else $error("calibration outside window");
  a_cal_standby: assert property (!hw_standby_n [*3] |-> !black_cal_active)
    else $error("calibration in standby");
  a_ccd_gain: assert property (!input_channel_select && $stable(pga_gain_code)
    && $stable(input_channel_select) |-> pga_gain_step ==
    (pga_gain_code > 10'h2FF ? 10'h2FF : pga_gain_code)) else $error("ccd gain step");
  a_video_gain: assert property (input_channel_select && $stable(pga_gain_code)
    && $stable(input_channel_select) |-> pga_gain_step ==
    (pga_gain_code < 10'h100 ? 10'h000 : pga_gain_code - 10'h100))
    else $error("video gain step");
  a_target_code: assert property ($stable(black_target_enable)
    && $stable(black_target_level) |-> black_target_code ==
    (black_target_enable ? 10'h014 + black_target_level : 10'h000))
    else $error("black target code");
  a_cfg_reset: assert property ($fell(rst) |-> conv_clock_delay_sel == 4'h0
    && !video_input_ground_short && !input_channel_select) else $error("cfg not reset");
  a_hold_word: assert property (out_valid && !out_ready |=> out_valid
    && $stable(out_data)) else $error("stalled word lost");
endmodule // ccdf_frontend_asserts

bind ccdf_frontend ccdf_frontend_asserts chk_u (.clk, .rst, .out_enable_n, .out_data_oe,
  .hw_standby_n, .global_standby, .black_cal_window_n, .black_cal_active,
  .input_channel_select, .pga_gain_code, .pga_gain_step, .black_target_enable,
  .black_target_level, .black_target_code, .conv_clock_delay_sel,
  .video_input_ground_short, .out_valid, .out_ready, .out_data);

// File: ccdf_sensor_model.sv
`timescale 1ns/100ps
module ccdf_sensor_model (
  input  logic       clk,
  input  logic       rst,
  input  logic       run,
  input  logic       conv_ready,
  output logic [9:0] conv_data,
  output logic       conv_valid,
  output logic       black_cal_window_n
);
  logic [9:0] data_q;
  logic [3:0] pix_q;
  always @(posedge clk) begin
    if (rst) begin
      data_q <= 10'h3C0;
      pix_q  <= 4'h0;
    end else if (conv_valid && conv_ready) begin
      data_q <= data_q + 10'h001;
      pix_q  <= pix_q + 4'h1;
    end
  end
  assign conv_valid = run;
  // Idle bus shows inverted data
  assign conv_data = run ? data_q : ~data_q;
  // Pixels 1..3 of a line are optical black
  assign black_cal_window_n = !(run && pix_q != 4'h0 && pix_q < 4'h4);
endmodule // ccdf_sensor_model

// File: ccdf_frontend_tb.sv
`timescale 1ns/100ps
`include "ccdf_map.vh"
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t %s", $time, m); end end
module ccdf_frontend_tb;
  logic       clk, rst, serial_clk, serial_config_data, serial_sel_n, hw_standby_n;
  logic       blanking_pulse, out_enable_n, out_ready, run, video, gs;
  logic       conv_valid, conv_ready, black_cal_window_n, out_data_oe, out_valid;
  logic       video_input_ground_short, input_channel_select, global_standby;
  logic       aux_dac1_active, aux_dac2_active, black_settled;
  logic [9:0] conv_data, out_data, pga_gain_step, black_target_code;
  logic [3:0] conv_clock_delay_sel;
  logic [7:0] aux_dac1_code, aux_dac2_code, sample_delay_code;
  logic [9:0] q[$];
  int         fail_count = 0, num_checks = 0, cyc = 0, n;
  ccdf_frontend dut_u (.clk, .rst, .ce(1'b1), .serial_clk, .serial_config_data,
    .serial_sel_n, .hw_standby_n, .black_cal_window_n, .blanking_pulse, .conv_data,
    .conv_valid, .conv_ready, .out_enable_n, .out_ready, .out_data, .out_data_oe,
    .out_valid, .conv_clock_delay_sel, .video_input_ground_short, .input_channel_select,
    .pga_gain_code(), .pga_gain_step, .sample_delay_code, .black_target_enable(),
    .black_target_level(), .black_target_code, .black_cal_active(), .black_settled,
    .aux_dac1_code, .aux_dac2_code, .aux_dac1_active, .aux_dac2_active, .global_standby);
  ccdf_sensor_model sm_u (.clk, .rst, .run, .conv_ready, .conv_data, .conv_valid,
    .black_cal_window_n);
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [9:0] d, input logic [1:0] ld = 2'b00);
    logic [15:0] w;
    w = {ld, a, d};
    serial_sel_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_config_data <= w[i];
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    serial_sel_n <= 1'b1;
    serial_config_data <= ~w[0];
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_cfg();
    `CHK({conv_clock_delay_sel, video_input_ground_short, input_channel_select}, 6'h00, "rst")
    wr(`CCDF_ADDR_CFG2, 10'h3C6);
    `CHK({conv_clock_delay_sel, video_input_ground_short, input_channel_select}, 6'h3F, "c2")
    wr(`CCDF_ADDR_CFG2, 10'h000, 2'b01);
    `CHK({conv_clock_delay_sel, video_input_ground_short, input_channel_select}, 6'h3F, "ld")
    wr(`CCDF_ADDR_CFG2, 10'h280);
    `CHK({conv_clock_delay_sel, video_input_ground_short, input_channel_select}, 6'h28, "dl")
    $display("test cfg done");
  endtask
  task automatic t_gain();
    logic [9:0] c[7] = '{10'h000, 10'h2FF, 10'h300, 10'h3FF, 10'h100, 10'h200, 10'h2FF};
    for (int i = 0; i < 7; i++) begin
      wr(`CCDF_ADDR_CFG2, (i > 3) ? 10'h002 : 10'h000);
      wr(`CCDF_ADDR_PGA, c[i]);
      `CHK(pga_gain_step, (i > 3) ? c[i] - 10'h100 : (c[i] > 10'h2FF ? 10'h2FF : c[i]), "g")
    end
    wr(`CCDF_ADDR_BLACK, 10'h01F);
    `CHK(black_target_code, 10'h023, "target max")
    wr(`CCDF_ADDR_BLACK, 10'h00F);
    `CHK(black_target_code, 10'h000, "target off")
    $display("test gain done");
  endtask
  task automatic t_dac();
    wr(`CCDF_ADDR_DAC1, 10'h0A5);
    wr(`CCDF_ADDR_DAC2, 10'h35A);
    `CHK({aux_dac1_code, aux_dac2_code}, 16'hA55A, "dac codes")
    wr(`CCDF_ADDR_SDELAY, 10'h3A5);
    `CHK(sample_delay_code, 8'hA5, "delay code")
    for (int i = 0; i < 32; i++) begin
      hw_standby_n <= i[4];
      wr(`CCDF_ADDR_CTRL1, {i[3:0], 6'h00});
      gs = !i[4] || i[3];
      `CHK({global_standby, aux_dac1_active, aux_dac2_active}, {gs, !i[1] && (!gs || i[0]), !i[2] && (!gs || i[0])}, "dac")
    end
    hw_standby_n <= 1'b1;
    wr(`CCDF_ADDR_CTRL1, 10'h001);
    `CHK({aux_dac1_code, sample_delay_code, conv_clock_delay_sel}, 20'h00000, "soft reset")
    $display("test dac done");
  endtask
  task automatic t_stream(input logic vid, input logic blk);
    wr(`CCDF_ADDR_CFG2, {8'h00, vid, 1'b0});
    wr(`CCDF_ADDR_SDELAY, 10'h000);
    video <= vid;
    blanking_pulse <= blk;
    out_enable_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(out_data_oe, 1'b0, "bus floats")
    out_enable_n <= 1'b0;
    run <= 1'b1;
    n = 0;
    do begin @(posedge clk); #1 n++; end while (!out_valid && n < 20);
    `CHK(n, 6, "latency")
    `CHK(out_data_oe, 1'b1, "bus driven")
    for (int i = 0; i < 48; i++) begin
      @(posedge clk);
      out_ready <= (i < 16 || i > 31);
      if (i == 31) `CHK(conv_ready, 1'b0, "stall")
    end
    run <= 1'b0;
    for (int i = 0; i < 40 && q.size() > 0; i++) @(posedge clk);
    `CHK(q.size(), 0, "words lost")
    $display("test stream done");
  endtask
  task automatic t_settle();
    wr(`CCDF_ADDR_CTRL1, 10'h001);
    `CHK(black_settled, 1'b0, "settle clear")
    run <= 1'b1;
    repeat (5200) @(posedge clk);
    `CHK(black_settled, 1'b0, "settle early")
    repeat (300) @(posedge clk);
    `CHK(black_settled, 1'b1, "settle late")
    run <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(q.size(), 0, "settle words")
    $display("test settle done");
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  always @(posedge clk) begin
    if (conv_valid && conv_ready) q.push_back(blanking_pulse ? 10'h000 : !video ? conv_data :
      conv_data > 10'h3C3 ? 10'h3FF : conv_data + 10'h03C);
    if (out_valid && out_ready) begin
      if (q.size() > 0) `CHK(out_data, q.pop_front(), "word")
      else `CHK(1'b0, 1'b1, "spurious word")
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst, serial_clk, serial_config_data, serial_sel_n, hw_standby_n} = 5'h13;
    {blanking_pulse, out_enable_n, out_ready, run, video} = 5'h04;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_cfg();
    t_gain();
    t_dac();
    t_stream(1'b0, 1'b0);
    t_stream(1'b1, 1'b0);
    t_stream(1'b0, 1'b1);
    t_settle();
    end_sim();
  end
endmodule // ccdf_frontend_tb
